// >>> rtl/cpu_mode_status_indicator.sv
// mode sequencing, front lamps and register slave of the cpu module
`timescale 1ns/100ps
`default_nettype none

module switch_debounce
	import cpu_mode_pkg::*;
#(
	parameter int unsigned STABLE = DEBOUNCE_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic raw,
	output var  logic level,
	output var  logic settled
);
	typedef struct packed {
		logic             s1;
		logic             s2;
		logic             cand;
		logic             stable;
		logic             done;
		logic [DEB_W-1:0] cnt;
	} deb_t;

	deb_t s;
	deb_t next_s;

	// first stage feeds only the second; the filter looks at the second
	always_comb begin
		next_s = s;
		next_s.s1 = raw;
		next_s.s2 = s.s1;
		if (s.s2 != s.cand) begin
			next_s.cand = s.s2;
			next_s.cnt = '0;
		end else if (s.cnt != DEB_W'(STABLE - 1)) begin
			next_s.cnt = s.cnt + DEB_W'(1);
		end else begin
			next_s.stable = s.cand;
			next_s.done = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	// settled stays low until a whole stable window has passed
	assign level = s.stable;
	assign settled = s.done;
endmodule

module cpu_mode_status_indicator
	import cpu_mode_pkg::*;
#(
	parameter int unsigned SLOW_HALF  = SLOW_HALF_CYC,
	parameter int unsigned RAPID_HALF = RAPID_HALF_CYC,
	parameter int unsigned DEBOUNCE   = DEBOUNCE_CYC
) (
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire axi_req_t axi_req,
	output var  axi_rsp_t axi_rsp,
	input  wire logic     mode_switch_run,
	input  wire logic     momentary_switch_reset,
	input  wire logic     momentary_switch_overall,
	input  wire logic     external_stop,
	input  wire logic     battery_good,
	input  wire logic     multiprocessor,
	input  wire probe_t   reset_probe,
	input  wire probe_t   image_access,
	input  wire logic     cycle_time_exceeded,
	input  wire logic     first_port_ready,
	input  wire logic     second_port_used,
	input  wire logic     second_port_ready,
	output var  lamps_t   lamps,
	output var  actions_t actions
);
	typedef struct packed {
		cpu_state_t         st;
		stop_kind_t         kind;
		logic               mode_prev;
		logic               inhibit;
		logic               scanning;
		logic [INIT_W-1:0]  init_cnt;
		logic [255:0]       present;
		logic [FLASH_W-1:0] slow_cnt;
		logic [FLASH_W-1:0] rapid_cnt;
		logic               slow_ph;
		logic               rapid_ph;
		lamps_t             led;
		actions_t           act;
		logic               aw_got;
		logic [7:0]         awaddr;
		logic               w_got;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		axi_rsp_t           rsp;
	} state_t;

	state_t s;
	state_t next_s;

	logic mode_run;
	logic mode_ok;
	logic mc_reset;
	logic mc_overall;

	// switches pass through sync and debounce before the sequencer
	switch_debounce #(.STABLE(DEBOUNCE)) deb_mode (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (mode_switch_run),
		.level   (mode_run),
		.settled (mode_ok)
	);
	switch_debounce #(.STABLE(DEBOUNCE)) deb_reset (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (momentary_switch_reset),
		.level   (mc_reset),
		.settled ()
	);
	switch_debounce #(.STABLE(DEBOUNCE)) deb_overall (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (momentary_switch_overall),
		.level   (mc_overall),
		.settled ()
	);

	always_comb begin
		logic [3:0]  cmd;
		logic        rise;
		logic        fall;
		logic        do_write;
		logic [31:0] rd;
		cmd = '0;
		rise = mode_run && !s.mode_prev;
		fall = !mode_run && s.mode_prev;
		do_write = 1'b0;
		rd = '0;
		next_s = s;
		next_s.act = '0;

		// flash dividers, free running so lamps share one phase
		if (s.slow_cnt == FLASH_W'(SLOW_HALF - 1)) begin
			next_s.slow_cnt = '0;
			next_s.slow_ph = !s.slow_ph;
		end else begin
			next_s.slow_cnt = s.slow_cnt + FLASH_W'(1);
		end
		if (s.rapid_cnt == FLASH_W'(RAPID_HALF - 1)) begin
			next_s.rapid_cnt = '0;
			next_s.rapid_ph = !s.rapid_ph;
		end else begin
			next_s.rapid_cnt = s.rapid_cnt + FLASH_W'(1);
		end

		// write address and data taken in either order
		if (axi_req.awvalid && s.rsp.awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s.rsp.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = axi_req.wdata;
			next_s.wstrb = axi_req.wstrb;
		end
		if (s.rsp.bvalid && axi_req.bready)
			next_s.rsp.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
			do_write = 1'b1;
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = RESP_OKAY;
			if (s.awaddr[7:2] == CMD_OFS[7:2]) begin
				if (s.wstrb[0])
					cmd = s.wdata[3:0];
			end else if (s.awaddr[7:2] != STATUS_OFS[7:2]
					&& s.awaddr[7:2] != LAMPS_OFS[7:2]) begin
				next_s.rsp.bresp = RESP_SLVERR; // unmapped
			end
		end
		// readies stay low until the response is taken, one write in flight
		next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid && !do_write;
		next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid && !do_write;

		// read channel, answer one cycle after the address
		if (s.rsp.rvalid && axi_req.rready)
			next_s.rsp.rvalid = 1'b0;
		if (axi_req.arvalid && s.rsp.arready) begin
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rresp = RESP_OKAY;
			unique case (axi_req.araddr[7:2])
				CMD_OFS[7:2]:    rd = '0;
				STATUS_OFS[7:2]: rd = {26'h0, s.inhibit, s.kind, s.st};
				LAMPS_OFS[7:2]:  rd = {24'h0, s.led};
				default: next_s.rsp.rresp = RESP_SLVERR;
			endcase
			next_s.rsp.rdata = rd;
		end
		// one read in flight; a new address waits while data is offered
		next_s.rsp.arready = !next_s.rsp.rvalid;

		// edge detector arms only after the first settled sample, no false edge
		if (s.st != ST_START)
			next_s.mode_prev = mode_run;

		// operating-state sequencer
		unique case (s.st)
			ST_START: begin
				if (mode_ok) begin
					next_s.mode_prev = mode_run;
					next_s.inhibit = 1'b1;
					if (!mode_run) begin
						next_s.st = ST_STOP;
						next_s.kind = K_OVR;
					end else if (battery_good) begin
						next_s.st = ST_INIT;
						next_s.scanning = 1'b1;
						next_s.present = '0;
						next_s.init_cnt = INIT_W'(INIT_CYC - 1);
						next_s.act.image_clear = 1'b1;
					end else begin
						next_s.st = ST_STOP;
						next_s.kind = K_EXT;
					end
				end
			end
			ST_STOP: begin
				next_s.inhibit = 1'b1;
				if (s.kind == K_SELF && fall) begin
					next_s.kind = K_EXT;
				end else if (rise && battery_good) begin
					if (mc_overall) begin
						next_s.act.ram_erase = 1'b1;
						next_s.present = '0;
						next_s.kind = K_EXT;
						next_s.led.module_ack_timeout_led = 1'b0;
						next_s.led.addressing_error_led = 1'b0;
						next_s.led.cycle_time_exceeded_led = 1'b0;
					end else if (s.kind != K_OVR) begin
						next_s.st = ST_INIT;
						next_s.init_cnt = INIT_W'(INIT_CYC - 1);
						next_s.scanning = mc_reset;
						if (mc_reset) begin
							next_s.act.image_clear = 1'b1;
							next_s.present = '0;
							next_s.led.module_ack_timeout_led = 1'b0;
							next_s.led.addressing_error_led = 1'b0;
							next_s.led.cycle_time_exceeded_led = 1'b0;
						end
					end
				end else if (cmd[CMD_OVR_REQ]) begin
					next_s.kind = K_OVR;
				end else if (cmd[CMD_CHECK_ENTER]) begin
					next_s.st = ST_CHECK;
				end
			end
			ST_INIT: begin
				if (s.init_cnt == '0) begin
					next_s.st = ST_RUN;
					next_s.inhibit = 1'b0;
					next_s.scanning = 1'b0;
					next_s.act.program_from_start = s.scanning;
					next_s.act.program_resume = !s.scanning;
				end else begin
					next_s.init_cnt = s.init_cnt - INIT_W'(1);
				end
			end
			ST_RUN: begin
				if (fall || external_stop) begin
					next_s.st = ST_STOP;
					next_s.kind = K_EXT;
				end else if (cmd[CMD_OVR_REQ]) begin
					next_s.st = ST_STOP;
					next_s.kind = K_OVR;
				end else if (cmd[CMD_SELF_STOP]) begin
					next_s.st = ST_STOP;
					next_s.kind = K_SELF;
				end
				if (cycle_time_exceeded)
					next_s.inhibit = 1'b1;
			end
			ST_CHECK: begin
				if (cmd[CMD_CHECK_EXIT]) begin
					next_s.st = ST_STOP;
					next_s.kind = K_EXT;
				end
			end
			default: next_s.st = ST_START;
		endcase

		// presence scan during a reset's initial start
		if (s.st == ST_INIT && s.scanning && reset_probe.valid && reset_probe.ack
				&& (reset_probe.listed || !multiprocessor))
			next_s.present[{reset_probe.is_output, reset_probe.addr}] = 1'b1;

		// fault lamps are sticky; placed last so a new event beats a clear
		if (s.st == ST_RUN && image_access.valid) begin
			if (!s.present[{image_access.is_output, image_access.addr}])
				next_s.led.addressing_error_led = 1'b1;
			else if (!image_access.ack)
				next_s.led.module_ack_timeout_led = 1'b1;
		end
		if (s.st == ST_RUN && cycle_time_exceeded)
			next_s.led.cycle_time_exceeded_led = 1'b1;

		// run and stop lamps follow the next state so they never lag it
		next_s.led.run = next_s.st == ST_RUN;
		unique case (next_s.kind)
			K_EXT:   next_s.led.stop = next_s.st == ST_STOP;
			K_SELF:  next_s.led.stop = next_s.st == ST_STOP && next_s.slow_ph;
			K_OVR:   next_s.led.stop = next_s.st == ST_STOP && next_s.rapid_ph;
			default: next_s.led.stop = 1'b0;
		endcase
		next_s.led.output_inhibit = next_s.inhibit;
		next_s.led.first_serial_port = !first_port_ready;
		next_s.led.second_serial_port = second_port_used && !second_port_ready;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.st <= ST_START;
			s.kind <= K_EXT;
		end else begin
			s <= next_s;
		end
	end

	assign axi_rsp = s.rsp;
	assign lamps = s.led;
	assign actions = s.act;
endmodule

`default_nettype wire

// >>> shared/cpu_mode_pkg.sv
// constants, types and carriers of the cpu mode and status indicator
package cpu_mode_pkg;

	localparam int CLK_KHZ            = 200000;
	localparam int SLOW_FLASH_HALF_MS = 500;
	localparam int RAPID_FLASH_HALF_MS = 100;
	localparam int DEBOUNCE_MS        = 10;
	localparam int INIT_TIME_US       = 10;
	localparam int SLOW_HALF_CYC      = SLOW_FLASH_HALF_MS * CLK_KHZ;
	localparam int RAPID_HALF_CYC     = RAPID_FLASH_HALF_MS * CLK_KHZ;
	localparam int DEBOUNCE_CYC       = DEBOUNCE_MS * CLK_KHZ;
	localparam int INIT_CYC           = INIT_TIME_US * CLK_KHZ / 1000;
	localparam int FLASH_W            = 27;
	localparam int DEB_W              = 24;
	localparam int INIT_W             = 12;

	// register byte offsets
	localparam logic [7:0] CMD_OFS    = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] LAMPS_OFS  = 8'h08;

	// command bits, write one to act
	localparam int CMD_SELF_STOP   = 0;
	localparam int CMD_OVR_REQ     = 1;
	localparam int CMD_CHECK_ENTER = 2;
	localparam int CMD_CHECK_EXIT  = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {ST_START, ST_STOP, ST_INIT, ST_RUN, ST_CHECK} cpu_state_t;
	typedef enum logic [1:0] {K_EXT, K_SELF, K_OVR} stop_kind_t;

	typedef struct packed {
		logic run;
		logic stop;
		logic output_inhibit;
		logic module_ack_timeout_led;
		logic addressing_error_led;
		logic cycle_time_exceeded_led;
		logic first_serial_port;
		logic second_serial_port;
	} lamps_t;

	typedef struct packed {
		logic       valid;
		logic       is_output;
		logic [6:0] addr;
		logic       ack;
		logic       listed;
	} probe_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;

	typedef struct packed {
		logic ram_erase;
		logic image_clear;
		logic program_from_start;
		logic program_resume;
	} actions_t;

endpackage

// >>> sim/mode_checker.sv
// assertions on the lamp and action outputs of the mode controller
`timescale 1ns/100ps
`default_nettype none

module mode_checker
	import cpu_mode_pkg::*;
(
	input wire logic     aclk,
	input wire logic     aresetn,
	input wire logic     first_port_ready,
	input wire logic     second_port_used,
	input wire logic     second_port_ready,
	input wire lamps_t   lamps,
	input wire actions_t actions
);
	// one clock domain, so one clocking and one disable for all
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_run_excl: assert property (lamps.run |-> !lamps.stop)
		else $error("run and stop lit together");
	chk_init_dark: assert property (actions.image_clear |-> (!lamps.run && !lamps.stop) [*2])
		else $error("lamps lit during initial start");
	chk_start_run: assert property (actions.program_from_start |->
		lamps.run && !lamps.stop && !lamps.output_inhibit)
		else $error("reset did not end in run");
	chk_restart_run: assert property (actions.program_resume |->
		lamps.run && !lamps.stop && !lamps.output_inhibit)
		else $error("restart did not end in run");
	chk_erase_steady: assert property (actions.ram_erase |=> (lamps.stop && !lamps.run) [*6])
		else $error("stop lamp not steady after erase");
	chk_cycle_inhibit: assert property ($rose(lamps.cycle_time_exceeded_led) |->
		lamps.output_inhibit)
		else $error("overrun without inhibit");
	// the past guard skips the first edge after a reset release
	chk_first_port: assert property ($past(aresetn) |->
		lamps.first_serial_port == !$past(first_port_ready))
		else $error("first port lamp wrong");
	chk_second_port: assert property ($past(aresetn) |->
		lamps.second_serial_port == ($past(second_port_used) && !$past(second_port_ready)))
		else $error("second port lamp wrong");

	cover property (actions.ram_erase);
	cover property (actions.program_resume);
	cover property ($rose(lamps.cycle_time_exceeded_led));
endmodule

bind cpu_mode_status_indicator mode_checker u_chk (
	.aclk              (aclk),
	.aresetn           (aresetn),
	.first_port_ready  (first_port_ready),
	.second_port_used  (second_port_used),
	.second_port_ready (second_port_ready),
	.lamps             (lamps),
	.actions           (actions)
);

`default_nettype wire

// >>> sim/panel_model.sv
// operator panel: a chattering mode switch and the momentary switch
`timescale 1ns/100ps
`default_nettype none

module panel_model (
	input  wire logic aclk,
	input  wire logic want_run,
	input  wire logic want_reset,
	input  wire logic want_overall,
	output var  logic mode_switch_run,
	output var  logic momentary_switch_reset,
	output var  logic momentary_switch_overall
);
	logic [1:0] bounce = 2'h0;
	logic       last = 1'b0;

	// contacts chatter for three cycles after each throw
	always @(posedge aclk) begin
		last <= want_run;
		if (want_run != last)
			bounce <= 2'h3;
		else if (bounce != 2'h0)
			bounce <= bounce - 2'h1;
		mode_switch_run <= (bounce != 2'h0) ? !mode_switch_run : last;
	end

	// the operator holds the momentary switch through the throw
	assign momentary_switch_reset   = want_reset;
	assign momentary_switch_overall = want_overall;
endmodule

`default_nettype wire

// >>> sim/tb.sv
// self-checking bench of the mode controller and its lamps
`timescale 1ns/100ps
`default_nettype none

module tb;
	import cpu_mode_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	axi_req_t    req = '0;
	axi_rsp_t    rsp;
	logic        want_run = 1'b0, want_reset = 1'b0, want_overall = 1'b0;
	wire logic   sw_run, sw_rst, sw_ovr;
	logic        bat = 1'b1, ext = 1'b0, cyc_ex = 1'b0, mp = 1'b0;
	logic        p1 = 1'b1, p2u = 1'b0, p2r = 1'b0;
	probe_t      rprobe = '0, access = '0;
	lamps_t      lamps;
	actions_t    actions;
	wire logic [11:0] obs;
	int          miscompares = 0, tests_run = 0, cyc = 0, lit, tog;
	logic        prev;
	logic [1:0]  resp;
	logic [31:0] rdat;
	// first ready, second used, second ready, first lamp, second lamp
	logic [4:0]  rows [6] = '{5'h10, 5'h1c, 5'h0b, 5'h0e, 5'h19, 5'h02};

	assign obs = {lamps, actions};
	always #2.5 aclk = ~aclk;

	panel_model u_panel (.aclk(aclk), .want_run(want_run), .want_reset(want_reset),
		.want_overall(want_overall), .mode_switch_run(sw_run),
		.momentary_switch_reset(sw_rst), .momentary_switch_overall(sw_ovr));

	// short flash and debounce counts keep the run brief
	cpu_mode_status_indicator #(.SLOW_HALF(8), .RAPID_HALF(3), .DEBOUNCE(4)) dut (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.mode_switch_run(sw_run), .momentary_switch_reset(sw_rst),
		.momentary_switch_overall(sw_ovr), .external_stop(ext), .battery_good(bat),
		.multiprocessor(mp), .reset_probe(rprobe), .image_access(access),
		.cycle_time_exceeded(cyc_ex), .first_port_ready(p1), .second_port_used(p2u),
		.second_port_ready(p2r), .lamps(lamps), .actions(actions));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a hang counts as a failure
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	task settle(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// momentary switch first, then the throw, as an operator does it
	task move(input logic r, input logic rs, input logic ov);
		@(posedge aclk);
		want_reset <= rs;
		want_overall <= ov;
		@(posedge aclk);
		want_run <= r;
	endtask

	task wait_obs(input int i, input int lim);
		int k;
		k = 0;
		while (obs[i] !== 1'b1 && k < lim) begin
			@(posedge aclk);
			k++;
		end
		chk(k < lim, 1);
	endtask

	// counts lit cycles and edges of the stop lamp
	task watch(input int n);
		lit = 0;
		tog = 0;
		prev = lamps.stop;
		repeat (n) begin
			@(posedge aclk);
			lit += lamps.stop;
			tog += (lamps.stop != prev);
			prev = lamps.stop;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		resp = rsp.bresp;
		req.bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		resp = rsp.rresp;
		rdat = rsp.rdata;
		req.rready <= 1'b0;
	endtask

	task pulse_access(input logic [6:0] a, input logic ack);
		@(posedge aclk);
		access <= '{1'b1, 1'b0, a, ack, 1'b0};
		@(posedge aclk);
		access <= '0;
		settle(3);
	endtask

	initial begin
		settle(5);
		chk(obs, 12'h000);
		aresetn <= 1'b1;
		// power up at stop
		wait_obs(10, 60);
		watch(40);
		chk(tog >= 10, 1);
		chk({lamps.run, lamps.output_inhibit}, 2'b01);
		$display("end power-up");
		foreach (rows[i]) begin
			@(posedge aclk);
			{p1, p2u, p2r} <= rows[i][4:2];
			settle(2);
			chk({lamps.first_serial_port, lamps.second_serial_port}, rows[i][1:0]);
		end
		$display("end serial rows");
		move(1'b0, 1'b0, 1'b1);
		move(1'b1, 1'b0, 1'b1);
		wait_obs(3, 60);
		watch(20);
		chk(lit, 20);
		move(1'b1, 1'b0, 1'b0);
		move(1'b0, 1'b0, 1'b0);
		settle(20);
		$display("end overall reset");
		bat <= 1'b0;
		move(1'b0, 1'b1, 1'b0);
		move(1'b1, 1'b1, 1'b0);
		settle(40);
		chk(lamps[7:6], 2'b01);
		move(1'b0, 1'b0, 1'b0);
		bat <= 1'b1;
		settle(20);
		$display("end battery");
		move(1'b0, 1'b1, 1'b0);
		move(1'b1, 1'b1, 1'b0);
		wait_obs(2, 60);
		chk(lamps[7:6], 2'b00);
		move(1'b1, 1'b0, 1'b0);
		rprobe <= '{1'b1, 1'b0, 7'h03, 1'b1, 1'b0};
		@(posedge aclk);
		// shared use records only listed modules, so 5 stays absent
		mp <= 1'b1;
		rprobe <= '{1'b1, 1'b0, 7'h05, 1'b1, 1'b0};
		@(posedge aclk);
		mp <= 1'b0;
		rprobe <= '0;
		wait_obs(1, 2100);
		chk(lamps[7:5], 3'b100);
		$display("end reset");
		pulse_access(7'h09, 1'b0);
		chk({lamps.addressing_error_led, lamps.module_ack_timeout_led}, 2'b10);
		pulse_access(7'h05, 1'b0);
		chk(lamps.module_ack_timeout_led, 0);
		pulse_access(7'h03, 1'b1);
		chk(lamps.module_ack_timeout_led, 0);
		pulse_access(7'h03, 1'b0);
		chk(lamps.module_ack_timeout_led, 1);
		@(posedge aclk);
		cyc_ex <= 1'b1;
		@(posedge aclk);
		cyc_ex <= 1'b0;
		settle(3);
		chk({lamps.cycle_time_exceeded_led, lamps.output_inhibit}, 2'b11);
		@(posedge aclk);
		ext <= 1'b1;
		@(posedge aclk);
		ext <= 1'b0;
		settle(3);
		chk(lamps[7:6], 2'b01);
		watch(20);
		chk(lit, 20);
		$display("end faults");
		move(1'b0, 1'b0, 1'b0);
		settle(20);
		move(1'b1, 1'b0, 1'b0);
		wait_obs(0, 2100);
		chk(lamps[7:5], 3'b100);
		move(1'b0, 1'b0, 1'b0);
		settle(20);
		chk(lamps[7:6], 2'b01);
		move(1'b1, 1'b0, 1'b0);
		wait_obs(0, 2100);
		$display("end restart");
		wr(CMD_OFS, 32'h1 << CMD_SELF_STOP);
		chk(resp, RESP_OKAY);
		settle(3);
		watch(40);
		chk(tog >= 3 && tog <= 7, 1);
		rd(STATUS_OFS);
		chk(rdat[4:0], 5'b01001);
		move(1'b0, 1'b0, 1'b0);
		settle(20);
		watch(20);
		chk(lit, 20);
		wr(CMD_OFS, 32'h1 << CMD_OVR_REQ);
		settle(3);
		watch(40);
		chk({tog >= 10, lamps.run}, 2'b10);
		// unmapped place answers with an error
		rd(8'h0c);
		chk(resp, RESP_SLVERR);
		wr(8'h0c, 32'h0);
		chk(resp, RESP_SLVERR);
		$display("end registers");
		wr(CMD_OFS, 32'h1 << CMD_CHECK_ENTER);
		chk(lamps[7:6], 2'b00);
		rd(STATUS_OFS);
		chk(rdat[5:0], 6'h34);
		wr(CMD_OFS, 32'h1 << CMD_CHECK_EXIT);
		chk(lamps[7:6], 2'b01);
		$display("end program check");
		// a second reset at stop must bring back the power-up state
		@(posedge aclk);
		aresetn <= 1'b0;
		settle(2);
		chk({obs, rsp.awready, rsp.wready, rsp.arready}, 15'h0000);
		aresetn <= 1'b1;
		wait_obs(10, 60);
		chk({lamps.run, lamps.output_inhibit, rsp.awready, rsp.arready}, 4'b0111);
		$display("end second reset");
		tally_and_finish;
	end
endmodule

`default_nettype wire
